// ---- ssbt_consts.svh ----
`ifndef SSBT_CONSTS_SVH
`define SSBT_CONSTS_SVH

`define SSBT_ADDR_W            8
`define SSBT_OFS_BOUND0        8'h60
`define SSBT_OFS_BOUND1        8'h61
`define SSBT_OFS_LBT0          8'h64
`define SSBT_OFS_LBT1          8'h65
`define SSBT_BOUND_RESET       8'h00
`define SSBT_LBT_RESET         8'h00
`define SSBT_CMP_HI            30
`define SSBT_CMP_LO            23
`define SSBT_NIB_HI_MSB        7
`define SSBT_NIB_HI_LSB        4
`define SSBT_NIB_LO_MSB        3
`define SSBT_NIB_LO_LSB        0
`define SSBT_CS_SLOT0          4'h3
`define SSBT_CS_SLOT1          4'hC
`define SSBT_CS_NONE           4'h0
`define SSBT_ONE4              4'h1
`define SSBT_ZERO4             4'h0
`define SSBT_ZERO8             8'h00

`endif

// ---- ssbt_pkg.sv ----
package ssbt_pkg;

    typedef enum logic [1:0] {
        SSBT_IDLE  = 2'b00,
        SSBT_GAP   = 2'b01,
        SSBT_DATA  = 2'b11
    } ssbt_state_e;

    typedef logic [7:0] ssbt_byte_t;

endpackage

// ---- ssbt_slot_table.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ssbt_consts.svh"

module ssbt_slot_table
    import ssbt_pkg::*;
#(
    parameter int SLOTS = 2
) (
    input  wire logic             clk_in,
    input  wire logic             load_in,
    input  wire logic [8*SLOTS-1:0] bound_init_in,
    input  wire logic [8*SLOTS-1:0] lbt_init_in,
    input  wire logic             rd_in,
    input  wire logic [7:0]       addr_in,
    output logic      [7:0]       rd_data_out,
    output logic      [8*SLOTS-1:0] bound_out,
    output logic      [8*SLOTS-1:0] lbt_out
);

    initial begin
        if (SLOTS != 2) begin
            $error("ssbt_slot_table: only two slots supported");
        end
    end

    typedef struct packed {
        logic [8*SLOTS-1:0] bound;
        logic [8*SLOTS-1:0] lbt;
        logic [7:0]         rdata;
    } ssbt_tab_s;

    ssbt_tab_s tab_reg;
    ssbt_tab_s tab_next;

    // preload only on load, never by pci reset
    always_comb begin
        tab_next = tab_reg;
        if (load_in) begin
            tab_next.bound = bound_init_in;
            tab_next.lbt   = lbt_init_in;
        end
        tab_next.rdata = `SSBT_ZERO8;
        if (rd_in) begin
            case (addr_in)
                `SSBT_OFS_BOUND0: tab_next.rdata = tab_reg.bound[7:0];
                `SSBT_OFS_BOUND1: tab_next.rdata = tab_reg.bound[15:8];
                `SSBT_OFS_LBT0:   tab_next.rdata = tab_reg.lbt[7:0];
                `SSBT_OFS_LBT1:   tab_next.rdata = tab_reg.lbt[15:8];
                default:          tab_next.rdata = `SSBT_ZERO8;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        tab_reg <= tab_next;
    end

    assign rd_data_out = tab_reg.rdata;
    assign bound_out   = tab_reg.bound;
    assign lbt_out     = tab_reg.lbt;

endmodule

`default_nettype wire

// ---- ssbt_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ssbt_consts.svh"

// Summary of operation
// - two read-only 8-bit boundary registers hold each slot's upper limit.
// - slot 0 drives chip selects 1:0 and slot 1 drives chip selects 3:2.
// - each boundary is compared with address bits 30 down to 23.
// - soldered memory preloads size and timing values.
// - the preloaded boundary values replace a presence-detect rom.
// - boundary bits keep their value across pci and suspend resets.
// - each slot has a read-only 8-bit burst timing register; only preload sets it, no reset loads 00h.
// - the timing upper nibble equals select-to-read latency plus one.
// - the upper nibble counts clocks from second strobe to its data.
// - the second strobe follows the first by lower nibble plus one.
module ssbt_top
    import ssbt_pkg::*;
#(
    parameter int SLOTS = 2
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        preload_in,
    input  wire logic [7:0]  preload_bound0_in,
    input  wire logic [7:0]  preload_bound1_in,
    input  wire logic [3:0]  preload_select_to_read0_in,
    input  wire logic [3:0]  preload_select_to_read1_in,
    input  wire logic [3:0]  preload_gap0_in,
    input  wire logic [3:0]  preload_gap1_in,
    input  wire logic        pci_bus_reset_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic [31:0] mem_addr_in,
    input  wire logic        burst_start_in,
    output logic      [3:0]  chip_select_out,
    output logic             strobe_out,
    output logic             data_mark_out,
    output logic             busy_out
);

    initial begin
        if (SLOTS != 2) begin
            $error("ssbt_top: only two slots supported");
        end
    end

    function automatic logic [3:0] ssbt_cs_decode(
        input logic [7:0] a,
        input logic [7:0] b0,
        input logic [7:0] b1
    );
        if (a < b0) begin
            ssbt_cs_decode = `SSBT_CS_SLOT0;
        end else if (a < b1) begin
            ssbt_cs_decode = `SSBT_CS_SLOT1;
        end else begin
            ssbt_cs_decode = `SSBT_CS_NONE;
        end
    endfunction

    logic [15:0] bound_w;
    logic [15:0] lbt_w;
    logic [15:0] lbt_init;
    logic [7:0]  rdata_w;

    // upper nibble is latency plus one
    assign lbt_init = {
        4'(preload_select_to_read1_in + `SSBT_ONE4), preload_gap1_in,
        4'(preload_select_to_read0_in + `SSBT_ONE4), preload_gap0_in
    };

    // table is never touched by rst_in or pci_bus_reset_in
    ssbt_slot_table #(
        .SLOTS         (SLOTS)
    ) u_table (
        .clk_in        (clk_in),
        .load_in       (preload_in),
        .bound_init_in ({preload_bound1_in, preload_bound0_in}),
        .lbt_init_in   (lbt_init),
        .rd_in         (reg_rd_in),
        .addr_in       (reg_addr_in),
        .rd_data_out   (rdata_w),
        .bound_out     (bound_w),
        .lbt_out       (lbt_w)
    );

    typedef struct packed {
        ssbt_state_e  state;
        logic [3:0]   count;
        logic [3:0]   cs;
        logic         strobe;
        logic         mark;
        logic [3:0]   data_lat;
        logic         first_done;
        logic         busy;
    } ssbt_ctl_s;

    ssbt_ctl_s ctl_reg;
    ssbt_ctl_s ctl_next;

    logic [3:0] sel_cs;
    logic [7:0] sel_lbt;
    logic [7:0] addr_hi;

    always_comb begin
        addr_hi = mem_addr_in[`SSBT_CMP_HI:`SSBT_CMP_LO];
        sel_cs  = ssbt_cs_decode(addr_hi, bound_w[7:0], bound_w[15:8]);
        sel_lbt = (sel_cs == `SSBT_CS_SLOT1) ? lbt_w[15:8] : lbt_w[7:0];
    end

    always_comb begin
        ctl_next        = ctl_reg;
        ctl_next.strobe = 1'b0;
        ctl_next.mark   = 1'b0;
        case (ctl_reg.state)
            SSBT_IDLE: begin
                if (burst_start_in && sel_cs != `SSBT_CS_NONE) begin
                    ctl_next.cs     = sel_cs;
                    ctl_next.strobe = 1'b1;
                    ctl_next.count  =
                        sel_lbt[`SSBT_NIB_LO_MSB:`SSBT_NIB_LO_LSB];
                    ctl_next.data_lat =
                        sel_lbt[`SSBT_NIB_HI_MSB:`SSBT_NIB_HI_LSB];
                    ctl_next.state  = SSBT_GAP;
                end
            end
            SSBT_GAP: begin
                if (ctl_reg.count == `SSBT_ZERO4) begin
                    ctl_next.strobe = 1'b1;
                    ctl_next.count  = ctl_reg.data_lat;
                    ctl_next.state  = SSBT_DATA;
                end else begin
                    ctl_next.count = 4'(ctl_reg.count - `SSBT_ONE4);
                end
            end
            SSBT_DATA: begin
                if (ctl_reg.count <= `SSBT_ONE4) begin
                    ctl_next.mark  = 1'b1;
                    ctl_next.cs    = `SSBT_CS_NONE;
                    ctl_next.state = SSBT_IDLE;
                end else begin
                    ctl_next.count = 4'(ctl_reg.count - `SSBT_ONE4);
                end
            end
            default: begin
                ctl_next.state = SSBT_IDLE;
            end
        endcase
        ctl_next.first_done = 1'b0;
        ctl_next.busy       = (ctl_next.state != SSBT_IDLE);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || pci_bus_reset_in) begin
            ctl_reg <= '0;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    assign reg_rdata_out   = rdata_w;
    assign chip_select_out = ctl_reg.cs;
    assign strobe_out      = ctl_reg.strobe;
    assign data_mark_out   = ctl_reg.mark;
    assign busy_out        = ctl_reg.busy;

endmodule

`default_nettype wire

// ---- ssbt_top_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssbt_top_chk (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        pci_bus_reset_in,
    input wire logic [7:0]  preload_bound0_in,
    input wire logic [7:0]  preload_bound1_in,
    input wire logic [3:0]  preload_select_to_read0_in,
    input wire logic [3:0]  preload_select_to_read1_in,
    input wire logic [3:0]  preload_gap0_in,
    input wire logic [3:0]  preload_gap1_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic [31:0] mem_addr_in,
    input wire logic        burst_start_in,
    input wire logic [3:0]  chip_select_out,
    input wire logic        strobe_out,
    input wire logic        data_mark_out,
    input wire logic        busy_out
);
    logic [4:0] n_reg;
    logic       ph_reg;
    logic       sl_reg;
    wire logic [7:0] u = mem_addr_in[30:23];
    wire logic [3:0] g = sl_reg ? preload_gap1_in : preload_gap0_in;
    wire logic [3:0] l = sl_reg ? preload_select_to_read1_in
                                : preload_select_to_read0_in;
    wire logic       go = burst_start_in && !busy_out;
    // cycles since last strobe, strobe parity, slot of burst
    always_ff @(posedge clk_in) begin
        if (rst_in || pci_bus_reset_in) begin
            n_reg <= 5'h00;
            ph_reg <= 1'h0;
            sl_reg <= 1'h0;
        end else if (strobe_out) begin
            n_reg <= 5'h01;
            ph_reg <= ~ph_reg;
            sl_reg <= chip_select_out[2];
        end else begin
            n_reg <= n_reg + 5'h01;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in || pci_bus_reset_in);
    property p_rd; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("rdata not idle");
    property p_cs;
        strobe_out |-> chip_select_out == 4'h3 || chip_select_out == 4'hC;
    endproperty
    a_cs: assert property (p_cs) else $error("bad selects");
    property p_s0;
        go && u < preload_bound0_in |=> strobe_out && chip_select_out == 4'h3;
    endproperty
    a_s0: assert property (p_s0) else $error("slot0 decode");
    property p_s1;
        go && u >= preload_bound0_in && u < preload_bound1_in
            |=> strobe_out && chip_select_out == 4'hC;
    endproperty
    a_s1: assert property (p_s1) else $error("slot1 decode");
    property p_no; go && u >= preload_bound1_in |=> !busy_out; endproperty
    a_no: assert property (p_no) else $error("no slot taken");
    property p_gap; strobe_out && ph_reg |-> n_reg == g + 5'h01; endproperty
    a_gap: assert property (p_gap) else $error("strobe gap");
    property p_lat;
        data_mark_out |->
            n_reg == (l == 4'hF ? 5'h01 : {1'h0, l} + 5'h01);
    endproperty
    a_lat: assert property (p_lat) else $error("data latency");
    property p_mk; data_mark_out |=> !data_mark_out; endproperty
    a_mk: assert property (p_mk) else $error("mark width");
endmodule
bind ssbt_top ssbt_top_chk i_ssbt_top_chk (.*);
`default_nettype wire

// ---- ssbt_sdram_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssbt_sdram_model (
    input  wire logic       clk_in,
    input  wire logic [3:0] chip_select_in,
    input  wire logic       strobe_in,
    output logic      [7:0] strobes_out
);
    initial strobes_out = 8'h00;
    // counts column strobes of a selected module
    always @(posedge clk_in) begin
        if (strobe_in && chip_select_in != 4'h0) begin
            strobes_out <= strobes_out + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- ssbt_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssbt_tb_top;
    logic clk_in = 0, rst_in = 1, preload_in = 0, pci_bus_reset_in = 0;
    logic reg_wr_in = 0, reg_rd_in = 0, burst_start_in = 0, rd_d = 0;
    logic strobe_out, data_mark_out, busy_out;
    logic [7:0] b0 = 0, b1 = 0, reg_addr_in = 0, reg_wdata_in = 0;
    logic [7:0] reg_rdata_out, strobes, q[$];
    logic [3:0] l0 = 0, l1 = 0, g0 = 0, g1 = 0, chip_select_out;
    logic [31:0] mem_addr_in = 0, x = 32'hBDC0, r;
    logic [4:0] mq[$];
    int fails = 0, checked = 0, cyc = 0, t = 0, bursts = 0;
    ssbt_top i_ssbt_top (.*, .preload_bound0_in(b0), .preload_bound1_in(b1),
        .preload_select_to_read0_in(l0), .preload_select_to_read1_in(l1),
        .preload_gap0_in(g0), .preload_gap1_in(g1));
    ssbt_sdram_model i_ssbt_sdram_model (.clk_in(clk_in),
        .chip_select_in(chip_select_out), .strobe_in(strobe_out),
        .strobes_out(strobes));
    always #5 clk_in = ~clk_in;
    function logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task chk(string n, logic [7:0] e, logic [7:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task stop_test;
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'h1;
        q.push_back(e);
        @(posedge clk_in);
        reg_rd_in <= 1'h0;
    endtask
    task bur(int s);
        logic [7:0] u;
        logic [3:0] g, l;
        r = rnd();
        u = s == 0 ? r % b0 : s == 1 ? b0 + r % (b1 - b0) : b1 + r % (256 - b1);
        g = s == 1 ? g1 : g0;
        l = s == 1 ? l1 : l0;
        @(posedge clk_in);
        mem_addr_in <= {r[31], u, r[22:0]};
        burst_start_in <= 1'h1;
        if (s < 2) mq.push_back(5'(g + l + 5'h02));
        if (s < 2) bursts++;
        repeat (2) @(posedge clk_in);
        burst_start_in <= 1'h0;
        for (int w = 0; w < 40 && busy_out !== 1'h0; w++) @(posedge clk_in);
    endtask
    // result watcher
    always @(posedge clk_in) begin
        cyc++;
        rd_d <= reg_rd_in;
        t <= (burst_start_in && !busy_out) ? 0 : t + 1;
        if (rd_d) chk("rdata", q.pop_front(), reg_rdata_out);
        if (data_mark_out) chk("mark", mq.pop_front(), t[7:0]);
        if (cyc == 5000) begin
            fails++;
            stop_test;
        end
    end
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'h0;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_in);
            r = rnd();
            b0 <= 8'h01 + r[5:0];
            b1 <= 8'h42 + r[11:6];
            l0 <= k ? 4'hE * (k - 1) : r[15:12] % 15;
            l1 <= k ? 4'hE * (k - 1) : r[19:16] % 15;
            g0 <= k ? 4'hF * (k - 1) : r[23:20];
            g1 <= k ? 4'hF * (k - 1) : r[27:24];
            preload_in <= 1'h1;
            @(posedge clk_in);
            preload_in <= 1'h0;
            for (int j = 0; j < 3; j++) begin
                @(posedge clk_in);
                reg_wr_in <= 1'h1;
                reg_addr_in <= 8'h60;
                reg_wdata_in <= r[7:0];
                @(posedge clk_in);
                reg_wr_in <= 1'h0;
                rd(8'h60, b0);
                rd(8'h61, b1);
                rd(8'h64, {l0 + 4'h1, g0});
                rd(8'h65, {l1 + 4'h1, g1});
                rd(8'h63, 8'h00);
                bur(0);
                bur(1);
                bur(2);
                @(posedge clk_in);
                pci_bus_reset_in <= j == 0;
                rst_in <= j == 1;
                @(posedge clk_in);
                {pci_bus_reset_in, rst_in} <= 2'h0;
            end
        end
        repeat (4) @(posedge clk_in);
        chk("strobes", 8'(bursts * 2), strobes);
        stop_test;
    end
endmodule
`default_nettype wire
